/* File: verification/ado_output_checker.sv */
// Port assertions for the converter output stage
`timescale 1ns/1ps
module ado_output_checker
  import ado_pkg::*;
(
  input wire logic      pclk,                  // Clock
  input wire logic      presetn,               // Reset, active low
  input wire logic      trim_phase,            // Trim step request
  input wire logic      trim_active,           // Trim running
  input wire ado_pair_t late_samples,          // Late buses
  input wire ado_pair_t early_samples,         // Early buses
  input wire logic      forwarded_data_strobe, // Data strobe
  input wire logic      mirror_data_strobe,    // Strobe copy
  input wire logic      out_of_range,          // Range flag
  input wire logic      irq                    // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any skew between the two strobes would split the receiver's capture window
  chk_mirror_same: assert property
    (mirror_data_strobe == forwarded_data_strobe)
    else $error("mirror strobe differs");
  chk_late_launch: assert property
    ($changed(late_samples) |-> $changed(forwarded_data_strobe))
    else $error("late bus moved without strobe");
  chk_early_launch: assert property
    ($changed(early_samples) |-> $changed(forwarded_data_strobe))
    else $error("early bus moved without strobe");
  // Trim checks allow two cycles for a launch already under way
  chk_trim_halt: assert property
    (trim_active [*3] |-> $stable(forwarded_data_strobe))
    else $error("strobe ran during trim");
  chk_trim_hold: assert property
    (trim_active [*3] |-> $stable(late_samples) && $stable(out_of_range))
    else $error("outputs moved during trim");
  chk_trim_cause: assert property
    ($rose(trim_active) |-> $past(trim_phase))
    else $error("trim without request");
  chk_trim_end: assert property
    ($fell(trim_phase) |-> ##[0:2] !trim_active)
    else $error("trim outlived request");
  // Sample edges come eight cycles apart, so a toggle is never followed soon
  chk_strobe_pace: assert property
    ($changed(forwarded_data_strobe) |=> $stable(forwarded_data_strobe) [*6])
    else $error("strobe toggled too fast");
  cover property ($rose(trim_active));
  cover property ($rose(out_of_range));
  cover property ($rose(irq));
endmodule

bind ado_output_stage ado_output_checker ado_output_checker_i (.pclk, .presetn, .trim_phase,
  .trim_active, .late_samples, .early_samples, .forwarded_data_strobe, .mirror_data_strobe,
  .out_of_range, .irq);

/* File: verification/ado_receiver.sv */
// Receiving logic that latches the late buses on every data strobe edge
`timescale 1ns/1ps
module ado_receiver
  import ado_pkg::*;
(
  input  wire logic      pclk,     // Oversampling clock
  input  wire logic      strobe,   // Forwarded data strobe
  input  wire ado_pair_t late_in,  // Late buses
  output ado_pair_t      cap_late, // Last latched word
  output int             edges     // Strobe edges seen
);
  logic prev;
  initial begin
    prev = 1'b0;
    cap_late = '0;
    edges = 0;
  end
  // Oversampled, not clocked by the strobe, since the strobe stops during trim
  always @(posedge pclk) begin
    prev <= strobe;
    if (strobe != prev) begin
      edges <= edges + 1;
      cap_late <= late_in;
    end
  end
endmodule

/* File: verification/test_adc_output_demux_data_clock.sv */
// Bench for the converter output stage with a reference model
`timescale 1ns/1ps
module test_adc_output_demux_data_clock;
  import ado_pkg::*;
  localparam logic [7:0] a_ctrl = {2'h0, `ADO_IDX_CTRL, 2'h0};
  localparam logic [7:0] a_fs = {2'h0, `ADO_IDX_FULL_SCALE, 2'h0};
  localparam logic [7:0] a_ext = {2'h0, `ADO_IDX_EXT_CFG, 2'h0};
  localparam logic [7:0] a_st = {2'h0, `ADO_IDX_STATUS, 2'h0};
  localparam logic [7:0] a_mask = {2'h0, `ADO_IDX_MASK, 2'h0};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_clk, trim_phase;
  logic        ext_pin, range_pin, early_oe, fwd, mir, oor, trim_active, irq, err;
  logic        demux, ddr, frozen, exp_strobe, exp_oor, exp_st;
  logic [7:0]  paddr;
  logic [11:0] i_level, q_level, fs_val;
  logic [31:0] pwdata, prdata, rd;
  ado_pair_t   sample, late_s, early_s, cap_late, hold, exp_late, exp_early;
  int          num_errors, samples_checked, cycles, rx_edges, exp_edges, phase;

  ado_output_stage ado_output_stage_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_clk, .sample, .i_level, .q_level,
    .trim_phase, .extended_ctrl_select_pin(ext_pin), .range_select_pin(range_pin),
    .late_samples(late_s), .early_samples(early_s), .early_oe,
    .forwarded_data_strobe(fwd), .mirror_data_strobe(mir), .out_of_range(oor),
    .trim_active, .irq);
  ado_receiver ado_receiver_i (.pclk, .strobe(fwd), .late_in(late_s), .cap_late,
    .edges(rx_edges));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; waits for pready, then idles a cycle
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic int mag(logic [11:0] v);
    return v[11] ? 4096 - int'(v) : int'(v);
  endfunction

  // Reference behaviour at one sample clock edge
  task automatic model_edge();
    int h;
    logic t;
    if (frozen) begin
      phase = 0;
      return;
    end
    h = ext_pin ? int'(range_pin ? `ADO_FS_HALF_HIGH : `ADO_FS_HALF_LOW) : int'(fs_val);
    t = mag(i_level) > h || mag(q_level) > h;
    if (t && !exp_oor) exp_st = 1'b1;
    exp_oor = t;
    t = 1'b1;
    if (!demux) exp_late = sample;
    else if (phase == 0) begin
      hold = sample;
      t = !ddr;
    end else begin
      exp_early = hold;
      exp_late = sample;
    end
    if (demux) phase = 1 - phase;
    if (t) exp_strobe = ~exp_strobe;
    if (t) exp_edges++;
  endtask

  task automatic compare_all();
    chk("late bus", exp_late, late_s);
    if (demux) chk("early bus", exp_early, early_s);
    chk("early enable", demux, early_oe);
    chk("data strobe", exp_strobe, fwd);
    chk("mirror strobe", exp_strobe, mir);
    chk("range flag", exp_oor, oor);
    chk("rx word", exp_late, cap_late);
    chk("rx edges", exp_edges, rx_edges);
  endtask

  // Sample clock periods of 200 ns; new data well after each detected edge
  task automatic edges_run(int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      conv_clk <= 1'b1;
      model_edge();
      repeat (4) @(posedge pclk);
      conv_clk <= 1'b0;
      repeat (3) @(posedge pclk);
      compare_all();
      sample <= ado_pair_t'(16'($urandom));
      i_level <= 12'($urandom);
      q_level <= 12'($urandom);
    end
  endtask

  task automatic trim(logic runs);
    trim_phase <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("trim running", runs, trim_active);
    frozen = runs;
    edges_run(3);
    trim_phase <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("trim over", 1'b0, trim_active);
    frozen = 1'b0;
  endtask

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {pclk, psel, penable, pwrite, conv_clk, trim_phase, presetn} = '0;
    {paddr, pwdata, sample, i_level, q_level} = '0;
    {ext_pin, range_pin, demux} = 3'h7;
    {ddr, frozen, exp_strobe, exp_oor, exp_st} = '0;
    {exp_late, exp_early} = '0;
    fs_val = `ADO_FS_ADJ_RST;
    void'($urandom(18));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, a_ctrl, '0);
    chk("ctrl reset", `ADO_CTRL_RST, rd);
    apb(1'b0, a_fs, '0);
    chk("scale reset", `ADO_FS_ADJ_RST, rd);
    apb(1'b0, a_ext, '0);
    chk("ext reset", `ADO_EXT_CFG_RST, rd);
    apb(1'b1, 8'h04, 32'hFFFF);
    chk("unmapped", 1'b1, err);
    // Demux single edge in pin mode, both range settings
    for (int r = 1; r >= 0; r--) begin
      range_pin <= r[0];
      repeat (6) @(posedge pclk);
      edges_run(8);
    end
    ext_pin <= 1'b0;
    apb(1'b1, a_fs, 32'h200);
    fs_val = 12'h200;
    apb(1'b1, a_ext, 32'h1);
    edges_run(8);
    trim(1'b1);
    trim(1'b0);
    apb(1'b1, a_ext, '0);
    trim(1'b1);
    // Pin mode ignores a stored skip bit, so the trim still stops the strobe
    ext_pin <= 1'b1;
    apb(1'b1, a_ext, 32'h1);
    repeat (4) @(posedge pclk);
    trim(1'b1);
    apb(1'b0, {2'h0, `ADO_IDX_STATE, 2'h0}, '0);
    chk("first trim done", 1'b1, rd[4]);
    chk("ext mode state", 1'b0, rd[2]);
    // Range interrupt masked, raised, cleared
    chk("irq masked", 1'b0, irq);
    apb(1'b1, a_mask, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", exp_st, irq);
    apb(1'b0, a_st, '0);
    chk("range status", exp_st, rd[0]);
    chk("trim status", 2'h3, rd[2:1]);
    apb(1'b1, a_st, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 1'b0, irq);
    apb(1'b1, a_ctrl, 32'h3);
    ddr = 1'b1;
    edges_run(8);
    apb(1'b1, a_ctrl, '0);
    demux = 1'b0;
    edges_run(8);
    close_out();
  end
endmodule

/* File: verilog/ado_defines.svh */
// Offsets, field positions, reset values and counts for the output stage
`ifndef ADO_DEFINES_SVH
`define ADO_DEFINES_SVH

`define ADO_SAMPLE_W        8
`define ADO_LEVEL_W         12
`define ADO_ADDR_W          8

// Register indices; byte address is four times the index
`define ADO_IDX_CTRL        4'h0
`define ADO_IDX_FULL_SCALE  4'h3
`define ADO_IDX_EXT_CFG     4'h9
`define ADO_IDX_STATUS      4'hA
`define ADO_IDX_MASK        4'hB
`define ADO_IDX_STATE       4'hC

// Control register fields
`define ADO_CTRL_DEMUX_BIT  0
`define ADO_CTRL_DDR_BIT    1
`define ADO_CTRL_RST        2'h1

// Extended configuration fields
`define ADO_EXT_TRIM_SKIP   0
`define ADO_EXT_CFG_RST     16'h0000

// Half full-scale thresholds (pin-selected and register reset value)
`define ADO_FS_HALF_LOW     12'h300
`define ADO_FS_HALF_HIGH    12'h400
`define ADO_FS_ADJ_RST      12'h400

// Interrupt status bits
`define ADO_ST_W            3
`define ADO_ST_OOR          0
`define ADO_ST_TRIM_START   1
`define ADO_ST_TRIM_DONE    2

// Pin synchroniser width: sample clock, extended select, range select
`define ADO_SYNC_W          3

`endif

/* File: verilog/ado_output_stage.sv */
// Output demultiplexer, forwarded data strobe and range flag of a dual converter
//
// Functional notes
// - Demux mode: early bus lags late bus by one input clock cycle.
// - Earlier sample of each pair goes on the delayed early bus.
// - Non-demux mode disables both early buses; receiver leaves them floating.
// - Out-of-range high when input exceeds half full scale, pin or register.
// - Mirror strobe reproduces the forwarded strobe exactly.
// - Both buses launch with the forwarded strobe; receiver latches on it.
// - Demux strobe runs at half input rate SDR, quarter rate DDR.
// - Non-demux forces DDR; strobe at half the input clock rate.
// - Strobe stops during termination trim phase of calibration by default.
// - In extended mode, trim-skip bit set skips the trim so the strobe keeps running.
// - Power-on trim always happens; only later trims are skipped.
// - Later sample of each pair goes on the non-delayed late bus.
`timescale 1ns/1ps
module ado_output_stage
  import ado_pkg::*;
(
  input  wire logic                     pclk,                      // 40 MHz block clock
  input  wire logic                     presetn,                   // Async reset, active low
  input  wire logic                     psel,                      // APB select
  input  wire logic                     penable,                   // APB enable
  input  wire logic                     pwrite,                    // APB direction
  input  wire logic [`ADO_ADDR_W-1:0]   paddr,                     // APB byte address
  input  wire logic [31:0]              pwdata,                    // APB write data
  output logic      [31:0]              prdata,                    // APB read data
  output logic                          pready,                    // APB ready
  output logic                          pslverr,                   // APB error
  input  wire logic                     conv_clk,                  // Input sample clock
  input  wire ado_pair_t                sample,                    // Conversion result
  input  wire logic [`ADO_LEVEL_W-1:0]  i_level,                   // Signed I input level
  input  wire logic [`ADO_LEVEL_W-1:0]  q_level,                   // Signed Q input level
  input  wire logic                     trim_phase,                // Calibration at trim step
  input  wire logic                     extended_ctrl_select_pin,  // Low: extended mode
  input  wire logic                     range_select_pin,          // High: larger range
  output ado_pair_t                     late_samples,              // Late I/Q buses
  output ado_pair_t                     early_samples,             // Early I/Q buses
  output logic                          early_oe,                  // Early buses driven
  output logic                          forwarded_data_strobe,     // Forwarded data clock
  output logic                          mirror_data_strobe,        // Copy of data clock
  output logic                          out_of_range,              // Range flag
  output logic                          trim_active,               // Trim really running
  output logic                          irq                        // Level interrupt
);

  // Synchronised pins
  logic [`ADO_SYNC_W-1:0] pins_f;
  logic                   clk_f;
  logic                   ecs_f;
  logic                   range_f;

  ado_pin_sync #(
    .W     (`ADO_SYNC_W)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({conv_clk, extended_ctrl_select_pin, range_select_pin}),
    .q_out   (pins_f)
  );

  assign clk_f   = pins_f[2];
  assign ecs_f   = pins_f[1];
  assign range_f = pins_f[0];

  // Register state
  logic [1:0]             ctrl;
  logic [`ADO_LEVEL_W-1:0] fs_adj;
  logic [15:0]            ext_cfg;
  logic [`ADO_ST_W-1:0]   status;
  logic [`ADO_ST_W-1:0]   mask;
  logic [1:0]             next_ctrl;
  logic [`ADO_LEVEL_W-1:0] next_fs_adj;
  logic [15:0]            next_ext_cfg;
  logic [`ADO_ST_W-1:0]   next_status;
  logic [`ADO_ST_W-1:0]   next_mask;

  // Datapath state
  logic                   clk_prev;
  logic                   phase;
  ado_pair_t              early_hold;
  logic                   next_phase;
  ado_pair_t              next_early_hold;
  ado_pair_t              next_late;
  ado_pair_t              next_early;
  logic                   next_strobe;
  logic                   next_oor;

  // Calibration state
  ado_cal_t               cal_state;
  ado_cal_t               next_cal_state;
  logic                   first_trim_done;
  logic                   next_first_trim_done;

  // Decoded controls
  logic                   ext_mode;
  logic                   demux_en;
  logic                   ddr_en;
  logic                   trim_skip_bit;
  logic                   conv_rise;
  logic [`ADO_LEVEL_W-1:0] half_range;
  logic                   wr_en;
  logic [3:0]             idx;
  logic                   mapped;
  logic [`ADO_ST_W-1:0]   events;

  // Magnitude of a two's complement level, saturating the most negative code
  function automatic logic [`ADO_LEVEL_W-1:0] mag(input logic [`ADO_LEVEL_W-1:0] v);
    logic [`ADO_LEVEL_W-1:0] n;
    n = ~v + 1'b1;
    if (!v[`ADO_LEVEL_W-1]) begin
      mag = v;
    end else if (n[`ADO_LEVEL_W-1]) begin
      mag = {1'b0, {(`ADO_LEVEL_W-1){1'b1}}};
    end else begin
      mag = n;
    end
  endfunction

  // Scale and trim-skip registers count only in extended mode; in pin mode the range pin sets the scale and no trim is skipped
  assign ext_mode      = ~ecs_f;
  assign trim_skip_bit = ext_mode & ext_cfg[`ADO_EXT_TRIM_SKIP];
  assign half_range    = ext_mode ? fs_adj
                       : (range_f ? `ADO_FS_HALF_HIGH : `ADO_FS_HALF_LOW);
  assign demux_en      = ctrl[`ADO_CTRL_DEMUX_BIT];
  assign ddr_en        = ctrl[`ADO_CTRL_DDR_BIT] | ~demux_en;
  assign conv_rise     = clk_f & ~clk_prev;
  assign trim_active   = (cal_state == CAL_TRIM);

  // Early buses stay released whole in non-demux mode
  assign early_oe           = demux_en;
  assign mirror_data_strobe = forwarded_data_strobe;

  // APB decode: zero wait states, error on unmapped word
  assign idx     = paddr[5:2];
  assign mapped  = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00)
                 && ((idx == `ADO_IDX_CTRL) || (idx == `ADO_IDX_FULL_SCALE)
                 || (idx == `ADO_IDX_EXT_CFG) || (idx == `ADO_IDX_STATUS)
                 || (idx == `ADO_IDX_MASK) || (idx == `ADO_IDX_STATE));
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & mapped;

  // Read mux over stored registers and live state
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && mapped) begin
      case (idx)
        `ADO_IDX_CTRL:       prdata = {30'h0, ctrl};
        `ADO_IDX_FULL_SCALE: prdata = {20'h0, fs_adj};
        `ADO_IDX_EXT_CFG:    prdata = {16'h0, ext_cfg};
        `ADO_IDX_STATUS:     prdata = {29'h0, status};
        `ADO_IDX_MASK:       prdata = {29'h0, mask};
        `ADO_IDX_STATE:      prdata = {27'h0, first_trim_done, trim_active,
                                       ext_mode, range_f, phase};
        default:             prdata = 32'h0000_0000;
      endcase
    end
  end

  // Calibration trim sequencing
  always_comb begin
    next_cal_state       = cal_state;
    next_first_trim_done = first_trim_done;
    case (cal_state)
      CAL_IDLE: begin
        if (trim_phase) begin
          // Power-on trim always runs, later ones obey the skip bit
          if (trim_skip_bit && first_trim_done) begin
            next_cal_state = CAL_SKIP;
          end else begin
            next_cal_state = CAL_TRIM;
          end
        end
      end
      CAL_TRIM: begin
        if (!trim_phase) begin
          next_cal_state       = CAL_IDLE;
          next_first_trim_done = 1'b1;
        end
      end
      CAL_SKIP: begin
        if (!trim_phase) begin
          next_cal_state = CAL_IDLE;
        end
      end
      default: next_cal_state = CAL_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_state       <= CAL_IDLE;
      first_trim_done <= 1'b0;
    end else begin
      cal_state       <= next_cal_state;
      first_trim_done <= next_first_trim_done;
    end
  end

  // Demultiplexer and strobe; nothing launches while the trim holds the strobe
  always_comb begin
    next_phase      = phase;
    next_early_hold = early_hold;
    next_late       = late_samples;
    next_early      = early_samples;
    next_strobe     = forwarded_data_strobe;
    next_oor        = out_of_range;
    if (trim_active) begin
      // Stopped strobe; pairing restarts cleanly afterwards
      next_phase = 1'b0;
    end else if (conv_rise) begin
      next_oor = (mag(i_level) > half_range) || (mag(q_level) > half_range);
      if (demux_en) begin
        if (!phase) begin
          // First of a pair waits one input cycle
          next_early_hold = sample;
          next_phase      = 1'b1;
          if (!ddr_en) begin
            next_strobe = ~forwarded_data_strobe;
          end
        end else begin
          // Pair launches together with a strobe edge
          next_early  = early_hold;
          next_late   = sample;
          next_phase  = 1'b0;
          next_strobe = ~forwarded_data_strobe;
        end
      end else begin
        // One word per input cycle on the late bus, both strobe edges used
        next_late   = sample;
        next_phase  = 1'b0;
        next_strobe = ~forwarded_data_strobe;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev              <= 1'b0;
      phase                 <= 1'b0;
      early_hold            <= '0;
      late_samples          <= '0;
      early_samples         <= '0;
      forwarded_data_strobe <= 1'b0;
      out_of_range          <= 1'b0;
    end else begin
      clk_prev              <= clk_f;
      phase                 <= next_phase;
      early_hold            <= next_early_hold;
      late_samples          <= next_late;
      early_samples         <= next_early;
      forwarded_data_strobe <= next_strobe;
      out_of_range          <= next_oor;
    end
  end

  // Interrupt events: range flag rising, trim start, trim end
  always_comb begin
    events = '0;
    events[`ADO_ST_OOR]        = next_oor & ~out_of_range;
    events[`ADO_ST_TRIM_START] = (cal_state == CAL_IDLE) && (next_cal_state == CAL_TRIM);
    events[`ADO_ST_TRIM_DONE]  = (cal_state == CAL_TRIM) && (next_cal_state == CAL_IDLE);
  end

  // Software registers; a new event wins over a write-one clear
  always_comb begin
    next_ctrl    = ctrl;
    next_fs_adj  = fs_adj;
    next_ext_cfg = ext_cfg;
    next_mask    = mask;
    next_status  = status;
    if (wr_en) begin
      case (idx)
        `ADO_IDX_CTRL:       next_ctrl    = pwdata[1:0];
        `ADO_IDX_FULL_SCALE: next_fs_adj  = pwdata[`ADO_LEVEL_W-1:0];
        `ADO_IDX_EXT_CFG:    next_ext_cfg = pwdata[15:0];
        `ADO_IDX_STATUS:     next_status  = status & ~pwdata[`ADO_ST_W-1:0];
        `ADO_IDX_MASK:       next_mask    = pwdata[`ADO_ST_W-1:0];
        default:             next_ctrl    = ctrl;
      endcase
    end
    next_status = next_status | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `ADO_CTRL_RST;
      fs_adj  <= `ADO_FS_ADJ_RST;
      ext_cfg <= `ADO_EXT_CFG_RST;
      status  <= '0;
      mask    <= '0;
      irq     <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      fs_adj  <= next_fs_adj;
      ext_cfg <= next_ext_cfg;
      status  <= next_status;
      mask    <= next_mask;
      irq     <= |(next_status & next_mask);
    end
  end

endmodule

/* File: verilog/ado_pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module ado_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,     // Block clock
  input  wire logic         presetn,  // Async reset, active low
  input  wire logic [W-1:0] d_in,     // Asynchronous inputs
  output logic      [W-1:0] q_out     // Filtered, synchronised levels
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q_out;

  // Per bit: accept a change only once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      always_comb begin
        next_q_out[b] = (s2[b] == s3[b]) ? s3[b] : q_out[b];
      end
    end
  endgenerate

  // First stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      q_out <= '0;
    end else begin
      s1    <= d_in;
      s2    <= s1;
      s3    <= s2;
      q_out <= next_q_out;
    end
  end

endmodule

/* File: verilog/ado_pkg.sv */
// Types shared by the output stage modules
package ado_pkg;
`include "ado_defines.svh"

  // One conversion result of both channels
  typedef struct packed {
    logic [`ADO_SAMPLE_W-1:0] i;
    logic [`ADO_SAMPLE_W-1:0] q;
  } ado_pair_t;

  // Calibration trim sequencing
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_TRIM,
    CAL_SKIP
  } ado_cal_t;

endpackage
